/* core/dwc_axi_width_conv.sv */
`timescale 1ns/100ps
`default_nettype none
module dwc_axi_width_conv #(
	parameter int SRC_LOG2 = dwc_pkg::DWC_DEF_SRC_LOG2,
	parameter int DST_LOG2 = dwc_pkg::DWC_DEF_DST_LOG2
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Upstream command
	input wire logic i_cmd_valid,
	output logic o_cmd_ready,
	input wire logic i_cmd_write,
	input wire logic [dwc_pkg::DWC_ADDR_W-1:0] i_cmd_addr,
	input wire logic [dwc_pkg::DWC_LEN_W-1:0] i_cmd_len,
	input wire logic [dwc_pkg::DWC_SIZE_W-1:0] i_cmd_size,
	input wire logic [1:0] i_cmd_burst,
	input wire logic i_cmd_lock,
	input wire logic [dwc_pkg::DWC_CACHE_W-1:0] i_cmd_cache,
	// Downstream command
	output logic o_dn_valid,
	input wire logic i_dn_ready,
	output logic o_dn_write,
	output logic [dwc_pkg::DWC_ADDR_W-1:0] o_dn_addr,
	output logic [dwc_pkg::DWC_LEN_W-1:0] o_dn_len,
	output logic [dwc_pkg::DWC_SIZE_W-1:0] o_dn_size,
	output logic [1:0] o_dn_burst,
	output logic o_dn_lock,
	output logic [dwc_pkg::DWC_CACHE_W-1:0] o_dn_cache,
	// Downstream response
	input wire logic i_rsp_valid,
	output logic o_rsp_ready,
	input wire logic [1:0] i_rsp_resp,
	input wire logic i_rsp_last,
	// Upstream response
	output logic o_up_valid,
	input wire logic i_up_ready,
	output logic [1:0] o_up_resp
);
	import dwc_pkg::*;

	localparam int AW = DWC_ADDR_W;
	localparam int CW = 1 + AW + DWC_LEN_W + DWC_SIZE_W + 2 + 1 + DWC_CACHE_W;
	localparam bit UP = DST_LOG2 > SRC_LOG2;
	localparam logic [AW-1:0] DMASK = AW'((1 << DST_LOG2) - 1);
	localparam logic [AW-1:0] D_BYTES = AW'(1 << DST_LOG2);
	localparam logic [DWC_SIZE_W-1:0] D_SIZE = DWC_SIZE_W'(DST_LOG2);
	localparam logic [AW-1:0] MAXB = AW'(DWC_MAX_BEATS);
	// Ratio must be 1:2..1:32 or 2:1..32:1
	if (SRC_LOG2 == DST_LOG2 || SRC_LOG2 - DST_LOG2 > DWC_MAX_RATIO_LOG2 ||
		DST_LOG2 - SRC_LOG2 > DWC_MAX_RATIO_LOG2 || SRC_LOG2 > 7 || DST_LOG2 > 7) begin : g_bad_ratio
		$error("dwc_axi_width_conv: unsupported width ratio");
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [DWC_SIZE_W-1:0] f_min_size(input logic [AW-1:0] s, input logic [AW-1:0] e);
		logic [DWC_SIZE_W-1:0] k;
		k = 3'h7;
		for (int i = 7; i >= 0; i--) begin
			if ((s >> i) == (e >> i)) begin
				k = DWC_SIZE_W'(i);
			end
		end
		return k;
	endfunction
	function automatic logic [AW-1:0] f_beats(input logic [AW-1:0] s, input logic [AW-1:0] e);
		return (e >> DST_LOG2) - (s >> DST_LOG2) + AW'(1);
	endfunction
	function automatic logic [1:0] f_merge(input logic [1:0] a, input logic [1:0] b);
		if (a == DWC_RESP_DECERR || b == DWC_RESP_DECERR) begin
			return DWC_RESP_DECERR;
		end else if (a == DWC_RESP_SLVERR || b == DWC_RESP_SLVERR) begin
			return DWC_RESP_SLVERR;
		end else begin
			return DWC_RESP_OKAY;
		end
	endfunction

	// ****************************************
	// Command decode
	// ****************************************
	dwc_state_e state_q;
	logic cmd_take;
	logic [AW-1:0] c_bytes, c_al, c_last, c_base, c_wtop, c_fend, c_dal, c_nb, c_dbeats;
	logic c_cacheable, c_pack, c_wide;
	assign o_cmd_ready = (state_q == DWC_IDLE);
	assign cmd_take = i_cmd_valid && o_cmd_ready;
	assign c_bytes = (AW'(i_cmd_len) + AW'(1)) << i_cmd_size;
	assign c_al = i_cmd_addr & ~((AW'(1) << i_cmd_size) - AW'(1));
	assign c_last = c_al + c_bytes - AW'(1);
	assign c_base = i_cmd_addr & ~(c_bytes - AW'(1));
	assign c_wtop = c_base + c_bytes - AW'(1);
	assign c_fend = c_al + (AW'(1) << i_cmd_size) - AW'(1);
	assign c_dal = i_cmd_addr & ~DMASK;
	assign c_nb = f_beats(c_al, c_last);
	assign c_dbeats = c_bytes >> DST_LOG2;
	assign c_cacheable = i_cmd_cache[DWC_CACHE_MOD_BIT];
	assign c_pack = c_cacheable && (UP || i_cmd_size < D_SIZE);
	assign c_wide = !UP && i_cmd_size > D_SIZE;
	// Plan: either one rewritten command, or regions cut into INCR bursts
	logic p_single, p_has_b, p_multi;
	logic [AW-1:0] p_addr, p_a_s, p_a_e, p_b_s, p_b_e;
	logic [DWC_LEN_W-1:0] p_len;
	logic [DWC_SIZE_W-1:0] p_size;
	logic [1:0] p_burst;
	logic [DWC_REP_W-1:0] p_rep;
	always_comb begin
		p_single = 1'b1;
		p_addr = i_cmd_addr;
		p_len = i_cmd_len;
		p_size = i_cmd_size;
		p_burst = i_cmd_burst;
		p_a_s = c_dal;
		p_a_e = c_last;
		p_b_s = '0;
		p_b_e = '0;
		p_has_b = 1'b0;
		p_rep = DWC_REP_W'(1);
		case (i_cmd_burst)
			DWC_BURST_INCR: begin
				if (c_pack) begin
					if (c_nb == AW'(1)) begin
						if (i_cmd_len != 8'h00) begin
							p_addr = c_al;
							p_len = 8'h00;
							p_size = f_min_size(c_al, c_last);
						end
					end else if (c_nb != AW'(i_cmd_len) + AW'(1)) begin
						p_addr = c_al;
						p_len = c_nb[DWC_LEN_W-1:0] - 8'h01;
						p_size = D_SIZE;
					end
				end else if (c_wide) begin
					p_single = 1'b0;
				end
			end
			DWC_BURST_WRAP: begin
				if (UP && c_cacheable) begin
					if (c_bytes <= D_BYTES) begin
						p_addr = c_base;
						p_len = 8'h00;
						p_size = f_min_size(c_base, c_wtop);
						p_burst = DWC_BURST_INCR;
					end else if ((c_al & DMASK) == '0) begin
						p_addr = c_al;
						p_len = c_dbeats[DWC_LEN_W-1:0] - 8'h01;
						p_size = D_SIZE;
					end else begin
						p_single = 1'b0;
						p_a_e = c_wtop;
						p_b_s = c_base;
						p_b_e = c_al - AW'(1);
						p_has_b = 1'b1;
					end
				end else if (c_wide) begin
					if (c_al == c_base) begin
						p_single = 1'b0;
						p_a_s = c_base;
						p_a_e = c_wtop;
					end else if (c_dbeats < AW'(DWC_WRAP_CAP)) begin
						p_addr = c_dal;
						p_len = c_dbeats[DWC_LEN_W-1:0] - 8'h01;
						p_size = D_SIZE;
					end else begin
						p_single = 1'b0;
						p_a_e = c_wtop;
						p_b_s = c_base;
						p_b_e = c_al - AW'(1);
						p_has_b = 1'b1;
					end
				end
			end
			DWC_BURST_FIXED: begin
				if (c_wide) begin
					if ((i_cmd_addr >> DST_LOG2) == (c_fend >> DST_LOG2)) begin
						p_size = f_min_size(i_cmd_addr, c_fend);
					end else begin
						p_single = 1'b0;
						p_a_e = c_fend;
						p_rep = DWC_REP_W'(i_cmd_len) + DWC_REP_W'(1);
					end
				end
			end
			default: begin
			end
		endcase
	end
	assign p_multi = !p_single && (p_has_b || p_rep > DWC_REP_W'(1) || f_beats(p_a_s, p_a_e) > MAXB);

	// ****************************************
	// Transaction registers
	// ****************************************
	logic single_q, multi_q, has_b_q, phase_b_q, write_q, lock_q;
	logic [AW-1:0] s_addr_q, cur_q, end_q, a_s_q, a_e_q, b_s_q, b_e_q;
	logic [DWC_LEN_W-1:0] s_len_q;
	logic [DWC_SIZE_W-1:0] s_size_q;
	logic [1:0] s_burst_q;
	logic [DWC_CACHE_W-1:0] cache_q;
	logic [DWC_REP_W-1:0] rep_q;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			{single_q, multi_q, has_b_q, write_q, lock_q} <= 5'h00;
			{s_addr_q, a_s_q, a_e_q, b_s_q, b_e_q} <= '0;
			{s_len_q, s_size_q, s_burst_q, cache_q} <= '0;
		end else if (cmd_take) begin
			single_q <= p_single;
			multi_q <= p_multi;
			has_b_q <= p_has_b;
			write_q <= i_cmd_write;
			lock_q <= i_cmd_lock;
			cache_q <= i_cmd_cache;
			s_addr_q <= p_addr;
			s_len_q <= p_len;
			s_size_q <= p_size;
			s_burst_q <= p_burst;
			{a_s_q, a_e_q, b_s_q, b_e_q} <= {p_a_s, p_a_e, p_b_s, p_b_e};
		end
	end

	// ****************************************
	// Segment emitter
	// ****************************************
	logic [1:0] buf_cnt_q;
	logic push, seg_full, emit_done;
	logic [AW-1:0] seg_left, seg_next;
	logic [DWC_LEN_W-1:0] seg_len;
	logic [CW-1:0] push_cmd;
	assign push = (state_q == DWC_EMIT) && (buf_cnt_q != 2'(DWC_BUF_DEPTH));
	assign seg_left = f_beats(cur_q, end_q);
	assign seg_full = seg_left > MAXB;
	assign seg_len = seg_full ? 8'hFF : seg_left[DWC_LEN_W-1:0] - 8'h01;
	assign seg_next = cur_q + (MAXB << DST_LOG2);
	assign emit_done = push && (single_q || (!seg_full && !(has_b_q && !phase_b_q) && rep_q == DWC_REP_W'(1)));
	// Exclusivity only survives when the transaction leaves as one burst
	assign push_cmd = single_q ?
		{write_q, s_addr_q, s_len_q, s_size_q, s_burst_q, lock_q && !multi_q, cache_q} :
		{write_q, cur_q, seg_len, D_SIZE, DWC_BURST_INCR, lock_q && !multi_q, cache_q};

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			{cur_q, end_q} <= '0;
			phase_b_q <= 1'b0;
			rep_q <= '0;
		end else if (cmd_take) begin
			cur_q <= p_a_s;
			end_q <= p_a_e;
			phase_b_q <= 1'b0;
			rep_q <= p_rep;
		end else if (push && !single_q) begin
			if (seg_full) begin
				cur_q <= seg_next;
			end else if (has_b_q && !phase_b_q) begin
				{cur_q, end_q, phase_b_q} <= {b_s_q, b_e_q, 1'b1};
			end else if (rep_q > DWC_REP_W'(1)) begin
				{cur_q, end_q, phase_b_q} <= {a_s_q, a_e_q, 1'b0};
				rep_q <= rep_q - DWC_REP_W'(1);
			end
		end
	end

	// ****************************************
	// Two-entry command buffer
	// ****************************************
	// A stalled completer must not drop a generated burst, so the emitter waits on full
	logic [CW-1:0] buf_mem [DWC_BUF_DEPTH];
	logic buf_wr_q, buf_rd_q, pop;

	assign o_dn_valid = (buf_cnt_q != 2'h0);
	assign pop = o_dn_valid && i_dn_ready;
	assign {o_dn_write, o_dn_addr, o_dn_len, o_dn_size, o_dn_burst, o_dn_lock, o_dn_cache} = buf_mem[buf_rd_q];

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
		end else if (push) begin
			buf_mem[buf_wr_q] <= push_cmd;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			{buf_wr_q, buf_rd_q} <= 2'h0;
			buf_cnt_q <= 2'h0;
		end else begin
			buf_wr_q <= buf_wr_q ^ push;
			buf_rd_q <= buf_rd_q ^ pop;
			buf_cnt_q <= buf_cnt_q + 2'(push) - 2'(pop);
		end
	end

	// ****************************************
	// Response merge and control
	// ****************************************
	logic [DWC_CNT_W-1:0] issued_q, done_q;
	logic [1:0] merged_q;
	logic first_q, rsp_take;

	assign o_rsp_ready = (state_q == DWC_EMIT) || (state_q == DWC_WAIT);
	assign rsp_take = i_rsp_valid && o_rsp_ready;
	assign o_up_valid = (state_q == DWC_RESP);
	assign o_up_resp = merged_q;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			{issued_q, done_q} <= '0;
			merged_q <= DWC_RESP_OKAY;
			first_q <= 1'b1;
		end else if (cmd_take) begin
			{issued_q, done_q} <= '0;
			first_q <= 1'b1;
		end else begin
			issued_q <= issued_q + DWC_CNT_W'(push);
			done_q <= done_q + DWC_CNT_W'(rsp_take && i_rsp_last);
			if (rsp_take) begin
				merged_q <= first_q ? i_rsp_resp : f_merge(merged_q, i_rsp_resp);
				first_q <= 1'b0;
			end
		end
	end

	// One input transaction at a time, so bursts of two inputs never share a command
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= DWC_IDLE;
		end else begin
			case (state_q)
				DWC_IDLE: if (cmd_take) state_q <= DWC_EMIT;
				DWC_EMIT: if (emit_done) state_q <= DWC_WAIT;
				DWC_WAIT: if (done_q == issued_q) state_q <= DWC_RESP;
				DWC_RESP: if (i_up_ready) state_q <= DWC_IDLE;
				default: state_q <= DWC_IDLE;
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	chk_lock_cleared: assert property (push && multi_q |-> !push_cmd[DWC_CACHE_W])
		else $error("exclusive kept on a split burst");
	chk_decerr_wins: assert property (rsp_take && i_rsp_resp == DWC_RESP_DECERR |=> merged_q == DWC_RESP_DECERR)
		else $error("decode error lost in merge");
	chk_slverr_over_okay: assert property (rsp_take && !first_q && i_rsp_resp == DWC_RESP_OKAY
		&& merged_q == DWC_RESP_SLVERR |=> merged_q == DWC_RESP_SLVERR)
		else $error("slave error overwritten by okay");
	chk_fixed_up_pass: assert property (cmd_take && UP && i_cmd_burst == DWC_BURST_FIXED
		|=> single_q && s_burst_q == DWC_BURST_FIXED && s_len_q == $past(i_cmd_len))
		else $error("upsized fixed burst altered");
	chk_noncache_pass: assert property (cmd_take && UP && !c_cacheable && i_cmd_burst != DWC_BURST_FIXED
		|=> single_q && s_size_q == $past(i_cmd_size) && s_burst_q == $past(i_cmd_burst))
		else $error("non-cacheable upsize was packed");
	chk_same_width_pass: assert property (cmd_take && !UP && i_cmd_burst == DWC_BURST_INCR
		&& i_cmd_size == D_SIZE |=> single_q && s_len_q == $past(i_cmd_len))
		else $error("output-width burst converted");
	chk_split_shape: assert property (push && !single_q
		|-> push_cmd[DWC_CACHE_W+3 +: DWC_SIZE_W] == D_SIZE && push_cmd[DWC_CACHE_W+1 +: 2] == DWC_BURST_INCR)
		else $error("generated burst not INCR of output width");
	chk_single_inflight: assert property (cmd_take |=> !o_cmd_ready ##1 (!o_cmd_ready || $past(o_up_valid)))
		else $error("second command taken during a transaction");
	chk_resp_after_all: assert property (o_up_valid |-> done_q == issued_q && issued_q != '0)
		else $error("response before all generated bursts completed");
	chk_resp_held: assert property (o_up_valid && !i_up_ready |=> o_up_valid && $stable(o_up_resp))
		else $error("upstream response dropped while stalled");
	chk_buf_no_overrun: assert property (buf_cnt_q == 2'(DWC_BUF_DEPTH) && !pop |=> $stable(buf_cnt_q))
		else $error("command buffer overrun");
	cov_split_multi: cover property (push && multi_q ##1 push);
	cov_two_regions: cover property (cmd_take && p_has_b);
	cov_buf_full: cover property (buf_cnt_q == 2'(DWC_BUF_DEPTH) && push == 1'b0 && state_q == DWC_EMIT);
	cov_merged_err: cover property (o_up_valid && o_up_resp == DWC_RESP_DECERR);
endmodule // dwc_axi_width_conv
`default_nettype wire

/* core/dwc_pkg.sv */
`default_nettype none
package dwc_pkg;
	// ****************************************
	// Burst and response encodings
	// ****************************************
	localparam logic [1:0] DWC_BURST_FIXED = 2'h0;
	localparam logic [1:0] DWC_BURST_INCR = 2'h1;
	localparam logic [1:0] DWC_BURST_WRAP = 2'h2;
	localparam logic [1:0] DWC_RESP_OKAY = 2'h0;
	localparam logic [1:0] DWC_RESP_EXOKAY = 2'h1;
	localparam logic [1:0] DWC_RESP_SLVERR = 2'h2;
	localparam logic [1:0] DWC_RESP_DECERR = 2'h3;

	// ****************************************
	// Field widths and positions
	// ****************************************
	localparam int DWC_ADDR_W = 32;
	localparam int DWC_LEN_W = 8;
	localparam int DWC_SIZE_W = 3;
	localparam int DWC_CACHE_W = 4;
	localparam int DWC_CACHE_MOD_BIT = 1;
	localparam int DWC_CNT_W = 10;
	localparam int DWC_REP_W = 9;

	// ****************************************
	// Limits and defaults
	// ****************************************
	localparam int DWC_MAX_BEATS = 256;
	localparam int DWC_WRAP_CAP = 16;
	localparam int DWC_MAX_RATIO_LOG2 = 5;
	localparam int DWC_DEF_SRC_LOG2 = 3;
	localparam int DWC_DEF_DST_LOG2 = 4;
	localparam int DWC_BUF_DEPTH = 2;

	// ****************************************
	// Control states
	// ****************************************
	typedef enum logic [1:0] {
		DWC_IDLE,
		DWC_EMIT,
		DWC_WAIT,
		DWC_RESP
	} dwc_state_e;
endpackage
`default_nettype wire

/* testbench/dwc_dn_completer.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Downstream completer model
// ****************************************
module dwc_dn_completer (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Command side
	input wire logic i_dn_valid,
	output logic o_dn_ready,
	input wire logic i_dn_write,
	input wire logic [7:0] i_dn_len,
	// Response side
	output logic o_rsp_valid,
	input wire logic i_rsp_ready,
	output logic [1:0] o_rsp_resp,
	output logic o_rsp_last,
	// Scenario control
	input wire logic i_slow,
	input wire logic i_clear,
	input wire logic [15:0] i_codes
);
	logic [2:0] beats_q[$];
	logic took_q;
	logic phase_q;
	int burst_q;
	int last_beat;

	// Reads answer len+1 beats, writes one; each of up to eight bursts uses its own code slot
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			beats_q.delete();
			took_q = 1'b0;
			burst_q = 0;
		end else begin
			if (i_clear)
				burst_q = 0;
			if (i_dn_valid && o_dn_ready) begin
				last_beat = i_dn_write ? 0 : int'(i_dn_len);
				for (int b = 0; b <= last_beat; b++)
					beats_q.push_back({b == last_beat, i_codes[2*(burst_q%8)+:2]});
				burst_q++;
			end
			took_q = o_rsp_valid && i_rsp_ready;
		end
	end

	// A beat once offered is held until taken; idle lines never repeat the last value
	always @(negedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_dn_ready = 1'b0;
			o_rsp_valid = 1'b0;
			o_rsp_resp = 2'h0;
			o_rsp_last = 1'b0;
			phase_q = 1'b0;
		end else begin
			phase_q = ~phase_q;
			o_dn_ready = !(i_slow && phase_q);
			if (took_q && o_rsp_valid) begin
				void'(beats_q.pop_front());
				o_rsp_valid = 1'b0;
			end
			if (!o_rsp_valid && beats_q.size() > 0 && !(i_slow && phase_q)) begin
				o_rsp_valid = 1'b1;
				{o_rsp_last, o_rsp_resp} = beats_q[0];
			end else if (!o_rsp_valid) begin
				o_rsp_resp = ~o_rsp_resp;
				o_rsp_last = ~o_rsp_last;
			end
		end
	end
endmodule // dwc_dn_completer
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import dwc_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	typedef struct {
		logic [31:0] a;
		logic [7:0] l;
		logic [2:0] s;
		logic [1:0] b;
		logic k;
		logic w;
		logic [3:0] c;
	} dwc_cmd_s;
	logic clk, rstn, cmd_valid, cmd_ready, cmd_write, cmd_lock, dn_valid, dn_ready, dn_write, dn_lock;
	logic rsp_valid, rsp_ready, rsp_last, up_valid, up_ready, slow, clear;
	logic [31:0] cmd_addr, dn_addr;
	logic [7:0] cmd_len, dn_len;
	logic [2:0] cmd_size, dn_size;
	logic [1:0] cmd_burst, dn_burst, rsp_resp, up_resp;
	logic [3:0] cmd_cache, dn_cache;
	logic [15:0] codes;
	dwc_cmd_s seen[$];
	int fails, checks;

	dwc_axi_width_conv #(.SRC_LOG2(3), .DST_LOG2(4)) u_dwc_axi_width_conv (
		.i_clk(clk), .i_resetn(rstn),
		.i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr),
		.i_cmd_len(cmd_len), .i_cmd_size(cmd_size), .i_cmd_burst(cmd_burst), .i_cmd_lock(cmd_lock),
		.i_cmd_cache(cmd_cache), .o_dn_valid(dn_valid), .i_dn_ready(dn_ready), .o_dn_write(dn_write),
		.o_dn_addr(dn_addr), .o_dn_len(dn_len), .o_dn_size(dn_size), .o_dn_burst(dn_burst),
		.o_dn_lock(dn_lock), .o_dn_cache(dn_cache), .i_rsp_valid(rsp_valid), .o_rsp_ready(rsp_ready),
		.i_rsp_resp(rsp_resp), .i_rsp_last(rsp_last), .o_up_valid(up_valid), .i_up_ready(up_ready),
		.o_up_resp(up_resp)
	);

	dwc_dn_completer u_dwc_dn_completer (
		.i_clk(clk), .i_resetn(rstn), .i_dn_valid(dn_valid), .o_dn_ready(dn_ready), .i_dn_write(dn_write),
		.i_dn_len(dn_len), .o_rsp_valid(rsp_valid), .i_rsp_ready(rsp_ready), .o_rsp_resp(rsp_resp),
		.o_rsp_last(rsp_last), .i_slow(slow), .i_clear(clear), .i_codes(codes)
	);

	// Log every generated command as it is popped
	always @(posedge clk) begin
		if (dn_valid && dn_ready)
			seen.push_back('{dn_addr, dn_len, dn_size, dn_burst, dn_lock, dn_write, dn_cache});
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic complete_run;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask

	// Bounded wait for the command ready (sel low) or the merged status (sel high)
	task automatic wait_hi(input logic sel, input int lim);
		int t;
		t = 0;
		while ((sel ? up_valid : cmd_ready) !== 1'b1) begin
			@(negedge clk);
			t++;
			if (t > lim) begin
				fails++;
				$display("[FAIL] %0t wait limit reached", $time);
				complete_run();
			end
		end
	endtask

	// One whole transaction: command in, all bursts out, one merged status back
	task automatic txn(input logic w, input logic [31:0] a, input logic [7:0] l, input logic [2:0] s,
			input logic [1:0] b, input logic k, input logic [3:0] c, input logic [15:0] cd, input int n,
			output logic [1:0] r);
		seen.delete();
		codes = cd;
		clear = 1'b1;
		{cmd_write, cmd_addr, cmd_len, cmd_size, cmd_burst, cmd_lock, cmd_cache} = {w, a, l, s, b, k, c};
		cmd_valid = 1'b1;
		wait_hi(1'b0, 200);
		@(negedge clk);
		cmd_valid = 1'b0;
		clear = 1'b0;
		wait_hi(1'b1, 600);
		r = up_resp;
		if (slow) begin
			repeat (3) @(negedge clk);
			chk(up_resp, r, "status held");
		end
		up_ready = 1'b1;
		@(negedge clk);
		up_ready = 1'b0;
		chk(up_valid, 1'b0, "single status");
		chk(seen.size(), n, "burst count");
		foreach (seen[i]) begin
			chk(seen[i].w, w, "direction");
			chk(seen[i].c, c, "cache kept");
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_incr;
		logic [1:0] r;
		logic [31:0] ad[7] = '{32'h100, 32'h100, 32'h108, 32'h100, 32'h108, 32'h100, 32'h100};
		logic [7:0] ln[7] = '{8'h0, 8'h1, 8'h1, 8'h3, 8'h3, 8'h3, 8'h1};
		logic [7:0] el[7] = '{8'h0, 8'h0, 8'h1, 8'h1, 8'h2, 8'h3, 8'h0};
		logic [2:0] es[7] = '{3'h3, 3'h4, 3'h3, 3'h4, 3'h4, 3'h3, 3'h3};
		for (int i = 0; i < 7; i++) begin
			slow = i[0];
			txn(i[0], ad[i], ln[i], i == 6 ? 3'h2 : 3'h3, DWC_BURST_INCR, 1'b0, i == 5 ? 4'h0 : 4'h2, 16'h0, 1, r);
			chk(seen[0].a, ad[i], "incr addr");
			chk(seen[0].l, el[i], "incr len");
			chk(seen[0].s, es[i], "incr size");
			chk(seen[0].b, DWC_BURST_INCR, "incr type");
			chk(r, DWC_RESP_OKAY, "incr status");
		end
	endtask

	task automatic t_wrap;
		logic [1:0] r;
		logic [31:0] ad[3] = '{32'h100, 32'h100, 32'h104};
		logic [7:0] ln[3] = '{8'h1, 8'h3, 8'h1};
		logic [2:0] sz[3] = '{3'h3, 3'h3, 3'h2};
		logic [7:0] el[3] = '{8'h0, 8'h1, 8'h0};
		logic [1:0] eb[3] = '{DWC_BURST_INCR, DWC_BURST_WRAP, DWC_BURST_INCR};
		for (int i = 0; i < 3; i++) begin
			txn(1'b0, ad[i], ln[i], sz[i], DWC_BURST_WRAP, 1'b0, 4'h2, 16'h0, 1, r);
			chk(seen[0].l, el[i], "wrap len");
			chk(seen[0].b, eb[i], "wrap type");
		end
		chk(seen[0].s, 3'h3, "small wrap size");
	endtask

	// Unaligned WRAP4 splits in two; status codes differ between the parts except in the all-OKAY run
	task automatic t_merge;
		logic [1:0] r;
		logic [15:0] cd[4] = '{16'h0008, 16'h000E, 16'h0003, 16'h0000};
		logic [1:0] er[4] = '{DWC_RESP_SLVERR, DWC_RESP_DECERR, DWC_RESP_DECERR, DWC_RESP_OKAY};
		for (int i = 0; i < 4; i++) begin
			slow = i[0];
			txn(i[1], 32'h108, 8'h3, 3'h3, DWC_BURST_WRAP, 1'b1, 4'h2, cd[i], 2, r);
			chk(r, er[i], "merged status");
			chk({seen[0].k, seen[1].k}, 2'h0, "split lock");
			chk({seen[0].b, seen[1].b}, {DWC_BURST_INCR, DWC_BURST_INCR}, "split type");
			chk(seen[0].l + seen[1].l, 32'h1, "split beats");
			chk({seen[0].s, seen[1].s}, 6'h24, "split size");
		end
	endtask

	task automatic t_fixed;
		logic [1:0] r;
		slow = 1'b0;
		txn(1'b1, 32'h104, 8'h3, 3'h2, DWC_BURST_FIXED, 1'b1, 4'h2, 16'h0, 1, r);
		chk({seen[0].a, seen[0].l}, {32'h104, 8'h3}, "fixed addr len");
		chk({seen[0].s, seen[0].b, seen[0].k}, {3'h2, DWC_BURST_FIXED, 1'b1}, "fixed fields");
	endtask

	// ****************************************
	// Clock, reset and sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		rstn = 1'b1;
		{cmd_valid, cmd_write, cmd_lock, up_ready, slow, clear} = 6'h01;
		{cmd_addr, cmd_len, cmd_size, cmd_burst, cmd_cache, codes} = '0;
		#1 rstn = 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk);
		chk({cmd_ready, dn_valid, rsp_ready, up_valid}, 4'h8, "reset outputs");
		rstn = 1'b1;
		@(negedge clk);
		t_incr();
		t_wrap();
		t_merge();
		t_fixed();
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
